// ===== serial_peer.sv
/*
  Remote serial peer: sends frames on rxd and captures frames seen on the txd line.
  Assumes asynchronous mode with bit_clks clocks per bit and a pulled-up txd line.
*/
`timescale 1ns/1ps
module serial_peer (
  input  wire logic       clk,
  input  wire logic       txd,
  input  wire logic [4:0] bit_clks,
  output logic            rxd
);
  logic [8:0] cap_q[$];
  logic [8:0] sh;

  initial rxd = 1'h1;

  // start low, nine bits lsb first, then back to idle high
  task automatic send(input logic [8:0] f);
    @(posedge clk) rxd <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      repeat (bit_clks) @(posedge clk);
      rxd <= (i < 9) ? f[i] : 1'h1;
    end
  endtask : send

  // sample mid-bit; a start that is gone at half bit is treated as a glitch
  always begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clk);
    if (txd === 1'h0) begin
      for (int i = 0; i < 9; i++) begin
        repeat (bit_clks) @(posedge clk);
        sh[i] = txd;
      end
      cap_q.push_back(sh);
    end
  end
endmodule : serial_peer

// ===== serial_pkg.sv
/*
  Constants and types for the serial transmit/receive datapath:
  register offsets, bit positions, reset values and bus responses.
  Assumes a 32-bit AXI4-Lite register port with byte addressing.
*/
package serial_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DATA   = 8'h00;  // serial_data_io
  localparam logic [7:0] OFF_STAT_A = 8'h04;  // serial_status_reg_a
  localparam logic [7:0] OFF_CTRL_B = 8'h08;  // serial_control_reg_b
  localparam logic [7:0] OFF_FMT_C  = 8'h0C;  // serial_format_reg_c
  localparam logic [7:0] OFF_BAUD   = 8'h10;  // baud_divisor

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STA_RXC  = 7;  // rx_complete_flag
  localparam int STA_TXC  = 6;  // tx_complete_flag, write one to clear
  localparam int STA_TX_BUFFER_EMPTY_FLAG = 5;  // tx_buffer_empty_flag
  localparam int STA_U2X  = 1;  // double_speed_bit
  localparam int CTL_TCIE = 6;  // tx_complete_irq_enable
  localparam int CTL_UEIE = 5;  // tx_empty_irq_enable
  localparam int CTL_RECEIVE_ENABLE_BIT = 4;  // receive_enable_bit
  localparam int CTL_TRANSMIT_ENABLE_BIT = 3;  // transmit_enable_bit
  localparam int CTL_SZ2  = 2;  // char_size_field bit 2
  localparam int CTL_RX8  = 1;  // received ninth bit
  localparam int CTL_TX8  = 0;  // tx_ninth_bit

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  FMT_RST   = 8'h06;   // async, no parity, one stop, 8 bits
  localparam logic [11:0] BAUD_RST  = 12'h000;
  localparam logic [2:0]  SIZE_NINE = 3'h7;
  localparam logic [3:0]  OS_N_M1   = 4'hF;    // 16 ticks per bit, minus one
  localparam logic [3:0]  OS_D_M1   = 4'h7;    // 8 ticks per bit at double speed
  localparam logic [3:0]  HALF_N    = 4'h7;
  localparam logic [3:0]  HALF_D    = 4'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // frame format as held in serial_format_reg_c
  typedef struct packed {
    logic       xck_master;   // bit 7
    logic       sync_mode;    // bit 6
    logic       parity_en;    // bit 5, parity_enable_bit
    logic       parity_odd;   // bit 4, parity_odd_select
    logic       two_stop;     // bit 3, stop_bits_select
    logic [1:0] size_lo;      // bits 2:1, char_size_field low bits
    logic       xck_pol;      // bit 0
  } fmt_t;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_BITS = 3'b100} rx_state_t;

endpackage : serial_pkg

// ===== usart_tx_rx_datapath.sv
/*
  Serial transmitter and receiver with AXI4-Lite registers.
  Assumes rxd_i and xck_i come from pins, asynchronous to aclk;
  the interrupt controller pulses tx_complete_irq_ack on service.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module usart_tx_rx_datapath
  import serial_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rxd_i,
  output logic                   txd_o,
  output logic                   txd_oe,
  input  wire logic              xck_i,
  output logic                   xck_o,
  output logic                   xck_oe,
  output logic                   tx_empty_irq,
  output logic                   tx_complete_irq,
  input  wire logic              tx_complete_irq_ack
);

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  logic              aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       wdata_r, rdata_r;
  logic [3:0]        wstrb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rd_mux;
  logic              rd_hit;

  wire do_wr  = aw_got_r && w_got_r && !bvalid_r;
  wire ar_hs  = s_axi_arvalid && s_axi_arready;
  wire [7:0] wa = 8'(aw_addr_r);
  wire [7:0] ra = 8'(s_axi_araddr);
  wire wr_hit = (wa == OFF_DATA) || (wa == OFF_STAT_A) || (wa == OFF_CTRL_B) ||
                (wa == OFF_FMT_C) || (wa == OFF_BAUD);
  wire wr_data = do_wr && (wa == OFF_DATA) && wstrb_r[0];
  wire wr_stat = do_wr && (wa == OFF_STAT_A) && wstrb_r[0];
  wire wr_ctrl = do_wr && (wa == OFF_CTRL_B) && wstrb_r[0];
  wire wr_fmt  = do_wr && (wa == OFF_FMT_C) && wstrb_r[0];
  wire wr_bd0  = do_wr && (wa == OFF_BAUD) && wstrb_r[0];
  wire wr_bd1  = do_wr && (wa == OFF_BAUD) && wstrb_r[1];
  wire rd_data = ar_hs && (ra == OFF_DATA);   // reading data pops the receive buffer

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // address and data are latched separately so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= '0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control and format registers
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_r;
  fmt_t        fmt_r;
  logic [11:0] baud_r;
  logic        u2x_r, txc_r, tx_full_r, rx_full_r, tx_on_r;
  logic [8:0]  tx_buf_r, rx_buf_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      fmt_r  <= fmt_t'(FMT_RST);
      baud_r <= BAUD_RST;
      u2x_r  <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= {1'b0, wdata_r[6:2], 1'b0, wdata_r[0]};
      if (wr_fmt)  fmt_r  <= fmt_t'(wdata_r[7:0]);
      if (wr_bd0)  baud_r[7:0]  <= wdata_r[7:0];
      if (wr_bd1)  baud_r[11:8] <= wdata_r[11:8];
      if (wr_stat) u2x_r  <= wdata_r[STA_U2X];
    end
  end

  wire [2:0] char_size = {ctrl_r[CTL_SZ2], fmt_r.size_lo};
  // codes 4..6 are reserved; they fall back to eight bits
  wire [3:0] n_bits = (char_size == SIZE_NINE) ? 4'd9 :
                      (char_size[2] ? 4'd8 : 4'(char_size) + 4'd5);
  wire [8:0] dmask  = 9'h1FF >> (4'd9 - n_bits);

  assign rd_hit = (ra == OFF_DATA) || (ra == OFF_STAT_A) || (ra == OFF_CTRL_B) ||
                  (ra == OFF_FMT_C) || (ra == OFF_BAUD);
  wire [7:0] stat_rd = {rx_full_r, txc_r, !tx_full_r, 3'b000, u2x_r, 1'b0};
  wire [7:0] ctrl_rd = {ctrl_r[7:2], rx_buf_r[8], ctrl_r[0]};
  assign rd_mux = (ra == OFF_DATA)   ? {24'h0, rx_buf_r[7:0]} :
                  (ra == OFF_STAT_A) ? {24'h0, stat_rd} :
                  (ra == OFF_CTRL_B) ? {24'h0, ctrl_rd} :
                  (ra == OFF_FMT_C)  ? {24'h0, fmt_r} :
                  (ra == OFF_BAUD)   ? {20'h0, baud_r} : 32'h0000_0000;

  // ---------------------------------------------------------------
  // baud ticks and serial clock
  // ---------------------------------------------------------------
  logic [11:0] baud_cnt_r;
  logic        xck_s1_r, xck_s2_r, xck_prev_r, xck_r, rxd_s1_r, rxd_s2_r;

  wire os_tick = (baud_cnt_r == 12'h000);
  wire master  = fmt_r.sync_mode && fmt_r.xck_master;
  wire [3:0] per_m1 = u2x_r ? OS_D_M1 : OS_N_M1;
  wire [3:0] half   = u2x_r ? HALF_D : HALF_N;
  wire xck_lvl  = master ? xck_r : xck_s2_r;
  wire xck_rise = xck_lvl && !xck_prev_r;
  wire xck_fall = !xck_lvl && xck_prev_r;
  // data changes on one edge and is sampled on the other
  wire tx_edge  = fmt_r.xck_pol ? xck_fall : xck_rise;
  wire rx_edge  = fmt_r.xck_pol ? xck_rise : xck_fall;

  // pins are synchronised; only the second stage feeds logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_cnt_r <= 12'h000;
      xck_r      <= 1'b0;
      xck_s1_r   <= 1'b0;
      xck_s2_r   <= 1'b0;
      xck_prev_r <= 1'b0;
      rxd_s1_r   <= 1'b1;
      rxd_s2_r   <= 1'b1;
    end else begin
      baud_cnt_r <= os_tick ? baud_r : baud_cnt_r - 12'h001;
      xck_r      <= master ? (xck_r ^ os_tick) : 1'b0;
      xck_s1_r   <= xck_i;
      xck_s2_r   <= xck_s1_r;
      xck_prev_r <= xck_lvl;
      rxd_s1_r   <= rxd_i;
      rxd_s2_r   <= rxd_s1_r;
    end
  end

  assign xck_o  = xck_r;
  assign xck_oe = master && (tx_on_r || ctrl_r[CTL_RECEIVE_ENABLE_BIT]);

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  tx_state_t   tx_state_r;
  logic [13:0] tx_sh_r;
  logic [3:0]  tx_cnt_r, tx_os_r;

  wire [8:0]  tx_masked = tx_buf_r & dmask;
  wire        tx_par    = (^tx_masked) ^ fmt_r.parity_odd;
  wire [3:0]  tail      = fmt_r.parity_en ? {3'b111, tx_par} : 4'hF;
  // ones above the frame keep the line high once the stops are out
  wire [12:0] payload   = {4'h0, tx_masked} | 13'({9'h1FF, tail} << n_bits);
  wire [13:0] frame     = {payload, 1'b0};
  wire [3:0]  frame_len = 4'd2 + n_bits + {3'b000, fmt_r.parity_en} +
                          {3'b000, fmt_r.two_stop};
  wire tx_bit_stb = fmt_r.sync_mode ? tx_edge : (os_tick && tx_os_r == per_m1);
  wire tx_last    = (tx_state_r == TX_SHIFT) && tx_bit_stb && (tx_cnt_r == 4'd1);
  wire tx_move    = tx_on_r && tx_full_r && ((tx_state_r == TX_IDLE) || tx_last);

  // buffer write wins over the move in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_full_r <= 1'b0;
      tx_buf_r  <= 9'h000;
    end else if (wr_data) begin
      tx_full_r <= 1'b1;
      tx_buf_r  <= {ctrl_r[CTL_TX8], wdata_r[7:0]};
    end else if (tx_move) begin
      tx_full_r <= 1'b0;
    end
  end

  // shifter: loads a whole frame, shifts ones in behind it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_r <= TX_IDLE;
      tx_sh_r    <= 14'h3FFF;
      tx_cnt_r   <= 4'h0;
      tx_os_r    <= 4'h0;
    end else begin
      case (tx_state_r)
        TX_IDLE, TX_SHIFT: begin
          if (tx_move) begin
            tx_state_r <= TX_SHIFT;
            tx_sh_r    <= frame;
            tx_cnt_r   <= frame_len;
            tx_os_r    <= 4'h0;
          end else if (tx_state_r == TX_SHIFT) begin
            if (os_tick) tx_os_r <= (tx_os_r == per_m1) ? 4'h0 : tx_os_r + 4'h1;
            if (tx_bit_stb) begin
              tx_sh_r  <= {1'b1, tx_sh_r[13:1]};
              tx_cnt_r <= tx_cnt_r - 4'h1;
              if (tx_last) tx_state_r <= TX_IDLE;
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // completion flag: setting beats both clearing paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txc_r   <= 1'b0;
      tx_on_r <= 1'b0;
    end else begin
      if (tx_last && !tx_full_r) txc_r <= 1'b1;
      else if (tx_complete_irq_ack || (wr_stat && wdata_r[STA_TXC])) txc_r <= 1'b0;
      // disabling only takes hold once shifter and buffer are empty
      tx_on_r <= ctrl_r[CTL_TRANSMIT_ENABLE_BIT] || tx_full_r || (tx_state_r == TX_SHIFT);
    end
  end

  assign txd_o  = tx_sh_r[0];
  assign txd_oe = tx_on_r;
  assign tx_empty_irq    = ctrl_r[CTL_UEIE] && !tx_full_r;
  assign tx_complete_irq = ctrl_r[CTL_TCIE] && txc_r;

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  rx_state_t   rx_state_r;
  logic [10:0] rx_sh_r;
  logic [3:0]  rx_cnt_r, rx_os_r;

  wire        rx_en   = ctrl_r[CTL_RECEIVE_ENABLE_BIT];
  // data, parity and only the first stop bit are gathered
  wire [3:0]  rx_need = n_bits + {3'b000, fmt_r.parity_en} + 4'd1;
  wire rx_bit_stb = fmt_r.sync_mode ? rx_edge : (os_tick && rx_os_r == per_m1);
  wire        rx_done = (rx_state_r == RX_BITS) && rx_bit_stb && (rx_cnt_r == 4'd1);
  wire [10:0] rx_sh_nxt = {rxd_s2_r, rx_sh_r[10:1]};
  wire [10:0] rx_align  = rx_sh_nxt >> (4'd11 - rx_need);
  wire [8:0]  rx_data   = rx_align[8:0] & dmask;

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      rx_state_r <= RX_IDLE;
      rx_sh_r    <= 11'h000;
      rx_cnt_r   <= 4'h0;
      rx_os_r    <= 4'h0;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          rx_os_r  <= 4'h0;
          rx_cnt_r <= rx_need;
          if (fmt_r.sync_mode) begin
            if (rx_edge && !rxd_s2_r) rx_state_r <= RX_BITS;
          end else if (!rxd_s2_r) begin
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          // a start bit must still be low at its middle to count
          if (os_tick) begin
            rx_os_r <= (rx_os_r == half) ? 4'h0 : rx_os_r + 4'h1;
            if (rx_os_r == half) rx_state_r <= rxd_s2_r ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (os_tick) rx_os_r <= (rx_os_r == per_m1) ? 4'h0 : rx_os_r + 4'h1;
          if (rx_bit_stb) begin
            rx_sh_r  <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_r - 4'h1;
            if (rx_done) rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // one-entry buffer; a new frame wins over a read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      rx_full_r <= 1'b0;
      rx_buf_r  <= 9'h000;
    end else if (rx_done) begin
      rx_full_r <= 1'b1;
      rx_buf_r  <= rx_data;
    end else if (rd_data) begin
      rx_full_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_tx_pin_owned;
    @(posedge aclk) disable iff (!aresetn) ctrl_r[CTL_TRANSMIT_ENABLE_BIT] |=> txd_oe;
  endproperty
  a_tx_pin_owned: assert property (p_tx_pin_owned) else $error("tx pin not taken");

  property p_write_clears_empty;
    @(posedge aclk) disable iff (!aresetn) wr_data |=> tx_full_r && !stat_rd[STA_TX_BUFFER_EMPTY_FLAG];
  endproperty
  a_write_clears_empty: assert property (p_write_clears_empty) else $error("empty flag stuck");

  property p_move_idle;
    @(posedge aclk) disable iff (!aresetn)
      (tx_on_r && tx_full_r && tx_state_r == TX_IDLE && !wr_data) |=> (tx_state_r == TX_SHIFT) && !tx_full_r;
  endproperty
  a_move_idle: assert property (p_move_idle) else $error("buffer not moved");

  property p_frame_len;
    @(posedge aclk) disable iff (!aresetn) tx_move |=> tx_cnt_r == $past(frame_len) && !txd_o;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("bad frame load");

  property p_txc_set;
    @(posedge aclk) disable iff (!aresetn) (tx_last && !tx_full_r && !wr_data) |=> txc_r ##1 txd_o;
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("complete flag not set");

  property p_txc_ack;
    @(posedge aclk) disable iff (!aresetn) (tx_complete_irq_ack && !tx_last) |=> !txc_r && !tx_complete_irq;
  endproperty
  a_txc_ack: assert property (p_txc_ack) else $error("complete flag not cleared");

  property p_idle_high;
    @(posedge aclk) disable iff (!aresetn) (tx_state_r == TX_IDLE) |-> txd_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while idle");

  property p_hold_enable;
    @(posedge aclk) disable iff (!aresetn)
      ($fell(ctrl_r[CTL_TRANSMIT_ENABLE_BIT]) && tx_state_r == TX_SHIFT && !tx_last) |=> txd_oe[*2];
  endproperty
  a_hold_enable: assert property (p_hold_enable) else $error("pin released early");

  property p_rx_store;
    @(posedge aclk) disable iff (!aresetn) rx_done |=> rx_full_r && rx_buf_r == $past(rx_data);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("frame not stored");

  property p_rx_off;
    @(posedge aclk) disable iff (!aresetn) !rx_en |=> rx_state_r == RX_IDLE && !rx_full_r;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver active while off");

  c_tx_frame:  cover property (@(posedge aclk) disable iff (!aresetn) tx_last && tx_full_r);
  c_rx_frame:  cover property (@(posedge aclk) disable iff (!aresetn) rx_done);
  c_slverr:    cover property (@(posedge aclk) disable iff (!aresetn) bvalid_r && bresp_r == RESP_SLVERR);
  c_rx_ninth:  cover property (@(posedge aclk) disable iff (!aresetn) rx_done && char_size == SIZE_NINE);

endmodule : usart_tx_rx_datapath

// ===== usart_tx_rx_datapath_test.sv
/*
  Self-checking bench: AXI4-Lite master tasks, random bytes over four frame formats.
  Assumes serial_peer on the far side; the external serial clock is left low.
*/
`timescale 1ns/1ps
module usart_tx_rx_datapath_test import serial_pkg::*;;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack;
  logic        awready, wready, bvalid, arready, rvalid, txd, txd_oe, rxd, te_irq, tc_irq, u;
  logic [7:0]  awaddr, araddr, fm;
  logic [31:0] wdata, rdata, seed, rd, d0, d1, d2, st;
  logic [1:0]  bresp, rresp, rs;
  logic [4:0]  bit_clks;
  int          failures, num_checks, nb;
  localparam logic [7:0] FMTS [4] = '{8'h06, 8'h24, 8'h3A, 8'h06};
  localparam int         NBS  [4] = '{8, 7, 6, 9};
  // released line is pulled up, so the peer never sees a stale level
  wire logic line = txd_oe ? txd : 1'h1;

  usart_tx_rx_datapath i_usart_tx_rx_datapath (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rxd_i(rxd), .txd_o(txd), .txd_oe(txd_oe), .xck_i(1'h0), .xck_o(),
    .xck_oe(), .tx_empty_irq(te_irq), .tx_complete_irq(tc_irq), .tx_complete_irq_ack(ack));
  serial_peer i_serial_peer (.clk(aclk), .txd(line), .bit_clks(bit_clks), .rxd(rxd));

  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // expected bits after the start bit: data, optional parity, then ones
  function automatic logic [8:0] fbits(logic [31:0] d);
    logic [8:0] f;
    f = 9'h1FF;
    for (int i = 0; i < nb; i++) f[i] = d[i];
    if (fm[5]) f[nb] = ^(d & ((32'h1 << nb) - 1)) ^ fm[4];
    return f;
  endfunction : fbits

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic axw(logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    bready <= 1'h0;
    chk("bvalid", 1, bvalid);
    chk("bresp", RESP_OKAY, bresp);
    if (bvalid !== 1'h1) summarize();
  endtask : axw

  task automatic axr(logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    rready <= 1'h0; rd = rdata; rs = rresp;
    if (rvalid !== 1'h1) begin chk("rvalid", 1, rvalid); summarize(); end
  endtask : axr

  // poll a status bit; running out of reads counts as a mismatch
  task automatic poll(int b);
    int n;
    n = 0;
    rd = '0;
    while (rd[b] !== 1'h1 && n < 60) begin axr(OFF_STAT_A); n++; end
    chk("poll", 1, rd[b]);
    if (rd[b] !== 1'h1) summarize();
  endtask : poll

  task automatic getcap(logic [8:0] e);
    int n;
    for (n = 0; n < 3000 && i_serial_peer.cap_q.size() == 0; n++) @(posedge aclk);
    if (n == 3000) begin chk("frame_seen", 1, 0); summarize(); end
    chk("frame", e, i_serial_peer.cap_q.pop_front());
  endtask : getcap

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h8; failures = 0; num_checks = 0; aresetn = 1'h0; ack = 1'h0; bit_clks = 5'h10;
    awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0; rready = 1'h0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    axr(OFF_STAT_A);
    chk("stat_rst", 32'h20, rd);
    chk("tc_irq_rst", 0, tc_irq);
    axr(OFF_FMT_C);
    chk("fmt_rst", FMT_RST, rd);
    for (int i = 0; i < 4; i++) begin
      fm = FMTS[i]; nb = NBS[i]; u = (i == 3);
      st = 32'h20 | {u, 1'h0};
      bit_clks <= u ? 5'h08 : 5'h10;
      axw(OFF_FMT_C, fm);
      axw(OFF_STAT_A, {u, 1'h0});  // empty flag position written as zero
      d0 = xs(); d1 = xs();
      // the last format runs nine-bit characters; ninth bit goes in first
      axw(OFF_CTRL_B, 32'h78 | {u, 1'h0, u & d0[8]});
      axw(OFF_DATA, d0);
      axw(OFF_CTRL_B, 32'h78 | {u, 1'h0, u & d1[8]});
      axw(OFF_DATA, d1);
      axr(OFF_STAT_A);
      chk("stat_full", st & 32'hDF, rd);
      chk("te_irq_full", 0, te_irq);
      axw(OFF_CTRL_B, 32'h70 | {u, 2'h0});
      chk("oe_pending", 1, txd_oe);
      getcap(fbits(d0));
      getcap(fbits(d1));
      poll(STA_TXC);
      chk("tc_irq", 1, tc_irq);
      chk("oe_done", 0, txd_oe);
      chk("te_irq", 1, te_irq);
      // alternate between interrupt service and write-one-to-clear
      if (i % 2) begin
        @(posedge aclk) ack <= 1'h1;
        @(posedge aclk) ack <= 1'h0;
      end
      else axw(OFF_STAT_A, 32'h40 | {u, 1'h0});
      axr(OFF_STAT_A);
      chk("stat_clr", st, rd);
      d2 = xs();
      i_serial_peer.send(fbits(d2));
      poll(STA_RXC);
      axr(OFF_CTRL_B);
      chk("rx_ninth", u & d2[8], rd[CTL_RX8]);
      axr(OFF_DATA);
      chk("rx_data", d2 & ((32'h1 << nb) - 1) & 32'hFF, rd);
      axr(OFF_STAT_A);
      chk("rxc_clr", st, rd);
      $display("test %0d done", i);
    end
    axr(8'h14);
    chk("unmapped", RESP_SLVERR, rs);
    summarize();
  end
endmodule : usart_tx_rx_datapath_test
